// >>> bmsl_map.svh
`ifndef BMSL_MAP_SVH
`define BMSL_MAP_SVH
`define BMSL_RAM_START 16'h0081
`define BMSL_VEC_SWI 16'h0083
`define BMSL_VEC_STEP 16'h0003
`define BMSL_ROM_VEC_LO 16'h3FE4
`define BMSL_ROM_VEC_HI 16'h3FEF
`define BMSL_MAX_LOAD 8'hFE
`define BMSL_BAUD 9600
`define BMSL_BUS_HZ 2000000
`define BMSL_EXT_AW 14
`define BMSL_ERASED 8'hFF
`endif

// >>> bmsl_pkg.sv
package bmsl_pkg;
  typedef enum logic [2:0] {
    BMSL_MODE_SINGLE,
    BMSL_MODE_JUMP_RAM,
    BMSL_MODE_LOAD_RAM,
    BMSL_MODE_VERIFY,
    BMSL_MODE_PROGRAM_INDICATOR_VERIFY
  } bmsl_mode_t;
endpackage

// >>> bmsl_loader.sv
`include "bmsl_map.svh"
module bmsl_loader import bmsl_pkg::*; #(
  parameter int CLK_HZ = 200000000,
  parameter int BAUD = `BMSL_BAUD,
  parameter int AW = `BMSL_EXT_AW
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic vpp_high_in,
  input wire logic boot_qualifier_pin_in,
  input wire logic boot_select_a_in,
  input wire logic boot_select_b_in,
  input wire logic serial_load_input_in,
  input wire logic [2:0] irq_src_in,
  input wire logic [7:0] ext_data_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ready_in,
  input wire logic sink_ready_in,
  output logic [2:0] mode_out,
  output logic boot_active_out,
  output logic [15:0] start_pc_out,
  output logic start_valid_out,
  output logic [15:0] vector_addr_out,
  output logic rom_vectors_out,
  output logic [7:0] load_data_out,
  output logic [7:0] load_addr_out,
  output logic load_valid_out,
  output logic load_error_out,
  output logic cnt_clock_out,
  output logic cnt_clear_out,
  output logic [AW-1:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_write_out,
  output logic mem_read_out,
  output logic program_indicator_out,
  output logic verify_indicator_out
);
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam logic [AW:0] MEM_SIZE = (AW+1)'(1) << AW;

  // ----------------------------------------
  // mode capture
  // ----------------------------------------
  bmsl_mode_t mode_reg, mode_next;
  logic seen_reg, seen_next;

  function automatic bmsl_mode_t decode_mode(input logic vpp, input logic q, input logic a, input logic b);
    if (!(vpp && q)) decode_mode = BMSL_MODE_SINGLE;
    else if (a) decode_mode = b ? BMSL_MODE_LOAD_RAM : BMSL_MODE_JUMP_RAM;
    else decode_mode = b ? BMSL_MODE_PROGRAM_INDICATOR_VERIFY : BMSL_MODE_VERIFY;
  endfunction

  always_comb begin
    mode_next = mode_reg;
    seen_next = seen_reg;
    if (!seen_reg) begin
      mode_next = decode_mode(vpp_high_in, boot_qualifier_pin_in, boot_select_a_in, boot_select_b_in);
      seen_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_reg <= BMSL_MODE_SINGLE;
      seen_reg <= 1'b0;
    end else if (clk_en_in) begin
      mode_reg <= mode_next;
      seen_reg <= seen_next;
    end
  end

  wire logic is_eprom = (mode_reg == BMSL_MODE_VERIFY) || (mode_reg == BMSL_MODE_PROGRAM_INDICATOR_VERIFY);
  assign mode_out = mode_reg;
  assign boot_active_out = seen_reg && (mode_reg != BMSL_MODE_SINGLE);
  assign rom_vectors_out = seen_reg && is_eprom;

  // ----------------------------------------
  // vectors
  // ----------------------------------------
  logic [15:0] vec_reg, vec_next;
  always_comb begin
    vec_next = `BMSL_ROM_VEC_LO;
    if (mode_reg == BMSL_MODE_JUMP_RAM || mode_reg == BMSL_MODE_LOAD_RAM) begin
      vec_next = `BMSL_VEC_SWI + 16'(irq_src_in) * `BMSL_VEC_STEP;
    end else if (is_eprom) begin
      vec_next = `BMSL_ROM_VEC_HI - 16'({irq_src_in, 1'b0});
    end
  end

  // ----------------------------------------
  // serial receiver and loader
  // ----------------------------------------
  typedef enum logic [2:0] {BMSL_RX_IDLE, BMSL_RX_START, BMSL_RX_DATA, BMSL_RX_STOP, BMSL_RX_DONE} bmsl_rx_t;
  bmsl_rx_t rx_reg, rx_next;
  logic [31:0] tick_reg, tick_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] got_reg, got_next;
  logic err_reg, err_next;
  logic start_reg, start_next;
  logic push;
  logic [7:0] push_data, push_addr;
  logic buf_ready;

  always_comb begin
    rx_next = rx_reg;
    tick_next = tick_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    count_next = count_reg;
    got_next = got_reg;
    err_next = err_reg;
    start_next = start_reg;
    push = 1'b0;
    push_data = sh_reg;
    push_addr = 8'(`BMSL_RAM_START) + got_reg - 8'h01;
    if (mode_reg == BMSL_MODE_JUMP_RAM && seen_reg) start_next = 1'b1;
    if (mode_reg == BMSL_MODE_LOAD_RAM && seen_reg) begin
      unique case (rx_reg)
        BMSL_RX_IDLE: if (!serial_load_input_in) begin
          rx_next = BMSL_RX_START;
          tick_next = 32'(HALF_CYC);
        end
        BMSL_RX_START: if (tick_reg == 32'd0) begin
          rx_next = serial_load_input_in ? BMSL_RX_IDLE : BMSL_RX_DATA;
          tick_next = 32'(BIT_CYC - 1);
          bit_next = 3'd0;
        end else tick_next = tick_reg - 32'd1;
        BMSL_RX_DATA: if (tick_reg == 32'd0) begin
          sh_next = {serial_load_input_in, sh_reg[7:1]};
          tick_next = 32'(BIT_CYC - 1);
          bit_next = bit_reg + 3'd1;
          if (bit_reg == 3'd7) rx_next = BMSL_RX_STOP;
        end else tick_next = tick_reg - 32'd1;
        BMSL_RX_STOP: if (tick_reg == 32'd0 && buf_ready) begin
          rx_next = BMSL_RX_IDLE;
          if (!serial_load_input_in) err_next = 1'b1;
          else if (got_reg == 8'd0) begin
            count_next = sh_reg;
            if (sh_reg > `BMSL_MAX_LOAD || sh_reg == 8'd0) err_next = 1'b1;
            got_next = 8'd1;
          end else begin
            push = 1'b1;
            got_next = got_reg + 8'd1;
          end
          if (got_next == count_next && got_next != 8'd0) begin
            rx_next = BMSL_RX_DONE;
            start_next = 1'b1;
          end
        end else if (tick_reg != 32'd0) tick_next = tick_reg - 32'd1;
        BMSL_RX_DONE: rx_next = BMSL_RX_DONE;
        default: rx_next = BMSL_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_reg <= BMSL_RX_IDLE;
      tick_reg <= 32'd0;
      bit_reg <= 3'd0;
      sh_reg <= 8'h00;
      count_reg <= 8'h00;
      got_reg <= 8'h00;
      err_reg <= 1'b0;
      start_reg <= 1'b0;
      vec_reg <= 16'h0000;
    end else if (clk_en_in) begin
      rx_reg <= rx_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      count_reg <= count_next;
      got_reg <= got_next;
      err_reg <= err_next;
      start_reg <= start_next;
      vec_reg <= vec_next;
    end
  end

  assign start_pc_out = `BMSL_RAM_START;
  assign start_valid_out = start_reg;
  assign load_error_out = err_reg;
  assign vector_addr_out = vec_reg;

  // ----------------------------------------
  // two-entry buffer toward RAM
  // ----------------------------------------
  logic [15:0] b_data_reg [2], b_data_next [2];
  logic [1:0] b_cnt_reg, b_cnt_next;
  assign buf_ready = (b_cnt_reg != 2'd2);

  always_comb begin
    b_data_next = b_data_reg;
    b_cnt_next = b_cnt_reg;
    if (b_cnt_reg != 2'd0 && sink_ready_in) begin
      b_data_next[0] = b_data_reg[1];
      b_cnt_next = b_cnt_next - 2'd1;
    end
    if (push) begin
      b_data_next[b_cnt_next[0]] = {push_addr, push_data};
      b_cnt_next = b_cnt_next + 2'd1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      b_data_reg[0] <= 16'h0000;
      b_data_reg[1] <= 16'h0000;
      b_cnt_reg <= 2'd0;
    end else if (clk_en_in) begin
      b_data_reg <= b_data_next;
      b_cnt_reg <= b_cnt_next;
    end
  end

  assign load_valid_out = (b_cnt_reg != 2'd0);
  assign load_addr_out = b_data_reg[0][15:8];
  assign load_data_out = b_data_reg[0][7:0];

  // ----------------------------------------
  // eprom copy and verify
  // ----------------------------------------
  typedef enum logic [2:0] {BMSL_EP_IDLE, BMSL_EP_CLEAR, BMSL_EP_PROGRAM_INDICATOR, BMSL_EP_VER_RD, BMSL_EP_VER_CMP,
                            BMSL_EP_STEP, BMSL_EP_DONE} bmsl_ep_t;
  bmsl_ep_t ep_reg, ep_next;
  logic [AW:0] addr_reg, addr_next;
  logic verify_pass_reg, verify_pass_next;
  logic ok_reg, ok_next;
  logic program_indicator_ind_reg, program_indicator_ind_next;
  logic ver_ind_reg, ver_ind_next;
  logic ck_reg, ck_next;
  logic clr_reg, clr_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [7:0] wd_reg, wd_next;

  always_comb begin
    ep_next = ep_reg;
    addr_next = addr_reg;
    verify_pass_next = verify_pass_reg;
    ok_next = ok_reg;
    program_indicator_ind_next = program_indicator_ind_reg;
    ver_ind_next = ver_ind_reg;
    ck_next = 1'b0;
    clr_next = 1'b0;
    wr_next = 1'b0;
    rd_next = 1'b0;
    wd_next = wd_reg;
    unique case (ep_reg)
      BMSL_EP_IDLE: if (seen_reg && is_eprom) begin
        ep_next = BMSL_EP_CLEAR;
        clr_next = 1'b1;
        verify_pass_next = (mode_reg == BMSL_MODE_VERIFY);
        program_indicator_ind_next = (mode_reg == BMSL_MODE_PROGRAM_INDICATOR_VERIFY);
        ok_next = 1'b1;
      end
      BMSL_EP_CLEAR: begin
        addr_next = '0;
        ep_next = verify_pass_reg ? BMSL_EP_VER_RD : BMSL_EP_PROGRAM_INDICATOR;
        rd_next = verify_pass_reg;
      end
      BMSL_EP_PROGRAM_INDICATOR: begin
        wd_next = ext_data_in;
        wr_next = 1'b1;
        ep_next = BMSL_EP_STEP;
      end
      // one settle cycle after each counter step, in both passes
      BMSL_EP_VER_RD: ep_next = verify_pass_reg ? BMSL_EP_VER_CMP : BMSL_EP_PROGRAM_INDICATOR;
      BMSL_EP_VER_CMP: begin
        rd_next = !mem_ready_in;
        if (mem_ready_in) begin
          if (mem_rdata_in != ext_data_in) ok_next = 1'b0;
          ep_next = BMSL_EP_STEP;
        end
      end
      BMSL_EP_STEP: if (mem_ready_in || verify_pass_reg) begin
        ck_next = 1'b1;
        addr_next = addr_reg + (AW+1)'(1);
        if (addr_next == MEM_SIZE) begin
          if (!verify_pass_reg) begin
            ck_next = 1'b0;
            verify_pass_next = 1'b1;
            program_indicator_ind_next = 1'b0;
            clr_next = 1'b1;
            ep_next = BMSL_EP_CLEAR;
          end else begin
            ver_ind_next = ok_reg;
            ep_next = BMSL_EP_DONE;
          end
        end else begin
          ep_next = BMSL_EP_VER_RD;
          rd_next = verify_pass_reg;
        end
      end
      BMSL_EP_DONE: ep_next = BMSL_EP_DONE;
      default: ep_next = BMSL_EP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ep_reg <= BMSL_EP_IDLE;
      addr_reg <= '0;
      verify_pass_reg <= 1'b0;
      ok_reg <= 1'b0;
      program_indicator_ind_reg <= 1'b0;
      ver_ind_reg <= 1'b0;
      ck_reg <= 1'b0;
      clr_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      wd_reg <= `BMSL_ERASED;
    end else if (clk_en_in) begin
      ep_reg <= ep_next;
      addr_reg <= addr_next;
      verify_pass_reg <= verify_pass_next;
      ok_reg <= ok_next;
      program_indicator_ind_reg <= program_indicator_ind_next;
      ver_ind_reg <= ver_ind_next;
      ck_reg <= ck_next;
      clr_reg <= clr_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      wd_reg <= wd_next;
    end
  end

  assign cnt_clock_out = ck_reg;
  assign cnt_clear_out = clr_reg;
  assign mem_addr_out = addr_reg[AW-1:0];
  assign mem_wdata_out = wd_reg;
  assign mem_write_out = wr_reg;
  assign mem_read_out = rd_reg;
  assign program_indicator_out = program_indicator_ind_reg;
  assign verify_indicator_out = ver_ind_reg;
endmodule

// >>> bmsl_checker_assertions.sv
module bmsl_checker import bmsl_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic vpp_high_in,
  input wire logic boot_qualifier_pin_in,
  input wire logic boot_select_a_in,
  input wire logic boot_select_b_in,
  input wire logic [2:0] irq_src_in,
  input wire logic sink_ready_in,
  input wire logic [2:0] mode_out,
  input wire logic boot_active_out,
  input wire logic [15:0] start_pc_out,
  input wire logic start_valid_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic rom_vectors_out,
  input wire logic [7:0] load_data_out,
  input wire logic [7:0] load_addr_out,
  input wire logic load_valid_out,
  input wire logic cnt_clock_out,
  input wire logic cnt_clear_out,
  input wire logic mem_write_out,
  input wire logic mem_read_out,
  input wire logic program_indicator_out,
  input wire logic verify_indicator_out
);
  // ---------------------------
  // edges since release, mode expected
  // ---------------------------
  logic [1:0] age_reg;
  logic [2:0] exp_reg;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      age_reg <= 2'h0;
      exp_reg <= 3'h0;
    end else begin
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
      if (age_reg == 2'h0) exp_reg <= !(vpp_high_in && boot_qualifier_pin_in) ? 3'h0 :
        boot_select_a_in ? (boot_select_b_in ? 3'h2 : 3'h1) : (boot_select_b_in ? 3'h4 : 3'h3);
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_settled; age_reg == 2'h3; endsequence
  sequence s_clr_gap; !cnt_clock_out ##1 !cnt_clear_out; endsequence
  property p_single; age_reg == 2'h3 && exp_reg == 3'h0 |-> mode_out == 3'h0 && !boot_active_out; endproperty
  a_single: assert property (p_single) else $error("single mode missed");
  property p_boot; age_reg == 2'h3 && exp_reg != 3'h0 |-> mode_out == exp_reg && boot_active_out; endproperty
  a_boot: assert property (p_boot) else $error("boot mode wrong");
  property p_hold; s_settled |=> $stable(mode_out); endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  property p_jump; age_reg == 2'h3 && mode_out == 3'h1 |-> start_valid_out && start_pc_out == 16'h0081; endproperty
  a_jump: assert property (p_jump) else $error("jump start wrong");
  property p_stall; load_valid_out && !sink_ready_in |=> load_valid_out && $stable({load_data_out, load_addr_out}); endproperty
  a_stall: assert property (p_stall) else $error("stalled word lost");
  property p_vec; age_reg == 2'h3 && mode_out inside {3'h1, 3'h2} && $stable(irq_src_in) && irq_src_in < 3'h5
    |-> vector_addr_out == 16'h0083 + 16'(irq_src_in) * 16'h0003; endproperty
  a_vec: assert property (p_vec) else $error("ram slot wrong");
  property p_romvec; s_settled |-> rom_vectors_out == (mode_out >= 3'h3); endproperty
  a_romvec: assert property (p_romvec) else $error("vector source wrong");
  property p_clear; cnt_clear_out |-> s_clr_gap; endproperty
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  property p_program_indicator; mem_write_out |-> program_indicator_out && mode_out == 3'h4; endproperty
  a_program_indicator: assert property (p_program_indicator) else $error("write without program state");
  property p_verify; verify_indicator_out |-> !program_indicator_out && mode_out >= 3'h3; endproperty
  a_verify: assert property (p_verify) else $error("verify indicator wrong");
endmodule
bind bmsl_loader bmsl_checker bmsl_checker_i (.*);

// >>> bmsl_partner.sv
module bmsl_partner #(parameter int AW = 4) (
  input wire logic sys_clk_in,
  input wire logic cnt_clock_in,
  input wire logic cnt_clear_in,
  input wire logic [AW-1:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic mem_write_in,
  input wire logic mem_read_in,
  output logic [7:0] ext_data_out,
  output logic [7:0] mem_rdata_out,
  output logic mem_ready_out
);
  logic [7:0] img [2**AW];
  logic [7:0] mem [2**AW];
  logic [AW-1:0] cnt_reg;
  int wait_cnt = -1;
  initial begin
    mem_rdata_out = 8'h5A;
    mem_ready_out = 1'b0;
    cnt_reg = '0;
  end
  assign ext_data_out = img[cnt_reg];
  // memory answers after 0..3 cycles, data toggles when not answering
  always @(posedge sys_clk_in) begin
    mem_ready_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (cnt_clear_in) cnt_reg <= '0;
    else if (cnt_clock_in) cnt_reg <= cnt_reg + 1'b1;
    if (mem_write_in) mem[mem_addr_in] <= mem_wdata_in;
    if ((mem_write_in || mem_read_in) && wait_cnt < 0 && !mem_ready_out) wait_cnt <= $urandom_range(3);
    else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 0) begin
      mem_ready_out <= 1'b1;
      mem_rdata_out <= mem[mem_addr_in];
      wait_cnt <= -1;
    end
  end
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 8;
  logic sys_clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, vpp_high_in = 1'b0;
  logic boot_qualifier_pin_in = 1'b0, boot_select_a_in = 1'b0, boot_select_b_in = 1'b0;
  logic serial_load_input_in = 1'b1, sink_ready_in = 1'b1;
  logic [2:0] irq_src_in = 3'h0, mode_out;
  logic [7:0] ext_data_in, mem_rdata_in, load_data_out, load_addr_out, mem_wdata_out, n;
  logic mem_ready_in, boot_active_out, start_valid_out, rom_vectors_out, load_valid_out, load_error_out;
  logic cnt_clock_out, cnt_clear_out, mem_write_out, mem_read_out, program_indicator_out, verify_indicator_out;
  logic [15:0] start_pc_out, vector_addr_out, got[$], want[$];
  logic [3:0] mem_addr_out, p;
  logic [2:0] m;
  int fails = 0, n_compared = 0, cyc = 0, clocks = 0;
  bmsl_loader #(.CLK_HZ(80), .BAUD(10), .AW(4)) bmsl_loader_i (.*);
  bmsl_partner #(.AW(4)) bmsl_partner_i (.sys_clk_in(sys_clk_in), .cnt_clock_in(cnt_clock_out),
    .cnt_clear_in(cnt_clear_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_write_in(mem_write_out), .mem_read_in(mem_read_out), .ext_data_out(ext_data_in),
    .mem_rdata_out(mem_rdata_in), .mem_ready_out(mem_ready_in));
  // ---------------------------
  // clock, watchdog, sink
  // ---------------------------
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cnt_clock_out) clocks++;
    if (load_valid_out && sink_ready_in) got.push_back({load_addr_out, load_data_out});
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  always @(negedge sys_clk_in) sink_ready_in = $urandom_range(3) != 0;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic boot(input logic [3:0] pins);
    @(negedge sys_clk_in);
    rst_b_in = 1'b0;
    {vpp_high_in, boot_qualifier_pin_in, boot_select_a_in, boot_select_b_in} = pins;
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    clocks = 0;
    got.delete();
    repeat (4) @(negedge sys_clk_in);
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      serial_load_input_in = f[k];
      repeat (BIT) @(negedge sys_clk_in);
    end
  endtask
  function automatic logic [2:0] exp_mode(input logic [3:0] q);
    if (q[3:2] != 2'b11) return 3'h0;
    return q[1] ? (q[0] ? 3'h2 : 3'h1) : (q[0] ? 3'h4 : 3'h3);
  endfunction
  function automatic logic [15:0] exp_vec(input logic [2:0] md, input logic [2:0] i);
    if (md == 3'h1 || md == 3'h2) return 16'h0083 + 16'(i) * 16'h0003;
    if (md >= 3'h3) return 16'h3FEF - 16'(i) * 16'h0002;
    return 16'h3FE4;
  endfunction
  // ---------------------------
  // scenarios
  // ---------------------------
  initial begin
    void'($urandom(32'hACFB));
    for (int i = 0; i < 16; i++) begin
      p = 4'(i);
      m = exp_mode(p);
      boot(p);
      irq_src_in = 3'($urandom_range(4));
      {vpp_high_in, boot_qualifier_pin_in, boot_select_a_in, boot_select_b_in} = ~p;
      repeat (3) @(negedge sys_clk_in);
      check("mode", mode_out, m);
      check("active", boot_active_out, m != 3'h0);
      check("run", start_valid_out, m == 3'h1);
      check("pc", start_pc_out, 16'h0081);
      check("romvec", rom_vectors_out, m >= 3'h3);
      check("vector", vector_addr_out, exp_vec(m, irq_src_in));
    end
    $display("mode test done");
    for (int c = 0; c < 2; c++) begin
      n = c ? 8'hFE : 8'h02;
      boot(4'hF);
      want.delete();
      send(n);
      for (int i = 1; i < n; i++) begin
        want.push_back({8'h80 + 8'(i), 8'($urandom)});
        send(want[i-1][7:0]);
      end
      for (int w = 0; w < 100 && got.size() < want.size(); w++) @(negedge sys_clk_in);
      check("words", got.size(), want.size());
      foreach (want[i]) check("word", got[i], want[i]);
      check("go", {start_valid_out, load_error_out}, 2'b10);
      send(8'h55);
      check("extra", got.size(), want.size());
    end
    for (int c = 0; c < 2; c++) begin
      boot(4'hF);
      send(c ? 8'hFF : 8'h00);
      repeat (BIT) @(negedge sys_clk_in);
      check("bad count", {load_error_out, start_valid_out}, 2'b10);
    end
    $display("serial test done");
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 16; i++) begin
        bmsl_partner_i.img[i] = 8'($urandom);
        bmsl_partner_i.mem[i] = t == 0 ? 8'hFF : bmsl_partner_i.img[i];
      end
      if (t == 2) bmsl_partner_i.mem[$urandom_range(15)] ^= 8'h10;
      boot(t == 0 ? 4'hD : 4'hC);
      check("program_indicator on", program_indicator_out, t == 0);
      if (t == 1) begin
        clk_en_in = 1'b0;
        repeat (40) @(negedge sys_clk_in);
        check("frozen", clocks, 0);
        clk_en_in = 1'b1;
      end
      // the clear between passes stands in for the last program step
      for (int w = 0; w < 3000 && clocks < (t == 0 ? 31 : 16); w++) @(negedge sys_clk_in);
      repeat (20) @(negedge sys_clk_in);
      check("steps", clocks, t == 0 ? 31 : 16);
      check("leds", {program_indicator_out, verify_indicator_out}, {1'b0, t != 2});
      for (int i = 0; i < 16; i++) if (t == 0) check("copy", bmsl_partner_i.mem[i], bmsl_partner_i.img[i]);
    end
    $display("eprom test done");
    end_sim();
  end
endmodule
